/* logic/acs_pkg.sv */
// Shared constants, types and helpers of the conversion sequencer.
// Assumes a single 200 MHz system clock, which is also the oscillator
// period used for the conversion-period table.
package acs_pkg;

    // ==================================================================
    // Conversion shape
    // ==================================================================
    localparam int ACS_RES_BITS = 12;
    localparam int ACS_TAD_TOTAL = 13;
    localparam logic [3:0] ACS_TAD_LAST = 4'hc;
    localparam logic [3:0] ACS_TAD_SETTLE = 4'h0;
    localparam logic [ACS_RES_BITS-1:0] ACS_MSB_MASK = 12'h800;
    localparam int ACS_PERIOD_W = 9;

    // ==================================================================
    // Field codes
    // ==================================================================
    localparam logic [3:0] ACS_MODE_SPECIAL_EVENT = 4'hb;
    localparam logic [1:0] ACS_CLK_OSC2 = 2'h0;
    localparam logic [1:0] ACS_CLK_OSC8 = 2'h1;
    localparam logic [1:0] ACS_CLK_OSC32 = 2'h2;
    localparam logic [1:0] ACS_CLK_RC = 2'h3;
    localparam logic [2:0] ACS_REF_INT_BOTH = 3'h2;
    localparam logic [2:0] ACS_REF_INT_HIGH = 3'h4;
    localparam logic [2:0] ACS_REF_INT_LOW = 3'h6;
    localparam logic [2:0] ACS_REF_INT_LOW_ONLY = 3'h7;

    // Period lengths counted in ticks.  A tick is one oscillator period,
    // or one edge of the RC oscillator, so one RC period is two ticks.
    localparam logic [ACS_PERIOD_W-1:0] ACS_TICKS_OSC2 = 9'h002;
    localparam logic [ACS_PERIOD_W-1:0] ACS_TICKS_OSC8 = 9'h008;
    localparam logic [ACS_PERIOD_W-1:0] ACS_TICKS_OSC32 = 9'h020;
    localparam logic [ACS_PERIOD_W-1:0] ACS_TICKS_RC = 9'h002;
    localparam int ACS_REF_SCALE_SHIFT = 3;

    // ==================================================================
    // Carriers
    // ==================================================================
    typedef struct packed {
        logic wr;
        logic converter_on;
        logic start;
    } acs_ctl_wr_t;

    typedef struct packed {
        logic [7:0] high_byte;
        logic [7:0] low_byte;
    } acs_result_t;

    // ==================================================================
    // Helpers
    // ==================================================================
    function automatic logic internal_ref_used(input logic [2:0] cfg);
        internal_ref_used = (cfg == ACS_REF_INT_BOTH) ||
                            (cfg == ACS_REF_INT_HIGH) ||
                            (cfg == ACS_REF_INT_LOW) ||
                            (cfg == ACS_REF_INT_LOW_ONLY);
    endfunction : internal_ref_used

    function automatic logic [ACS_PERIOD_W-1:0] tad_ticks(
        input logic [1:0] sel,
        input logic internal_ref
    );
        logic [ACS_PERIOD_W-1:0] base;
        case (sel)
            ACS_CLK_OSC2: base = ACS_TICKS_OSC2;
            ACS_CLK_OSC8: base = ACS_TICKS_OSC8;
            ACS_CLK_OSC32: base = ACS_TICKS_OSC32;
            default: base = ACS_TICKS_RC;
        endcase
        tad_ticks = internal_ref ? (base << ACS_REF_SCALE_SHIFT) : base;
    endfunction : tad_ticks

endpackage : acs_pkg

/* logic/acs_sequencer.sv */
// Control and timing of a successive-approximation converter.
// Assumes software drives the control write and flag clear as one-cycle
// pulses on sys_clk, that the special event pulse comes from logic on
// sys_clk, and that the RC oscillator and comparator are asynchronous.

// Overview of operation
// - One settling period, then twelve bit periods.
// - Clock select picks 2, 8, 32 Tosc or RC.
// - Internal reference multiplies the period by eight.
// - Done flag rises at fourteenth period's rise.
// - Start bit clears at fourteenth period's fall.
// - Special event trigger starts conversion when on.
// - Special event trigger clears the sixteen-bit timer.
// - Trigger ignored when off, timer still cleared.
// - Reset clears control and aborts conversion.
// - Reset leaves both result bytes unchanged.
// - Writing start begins conversion; hardware clears it.
// - Clearing start aborts and stores partial result.
// - Setting on and start together cancels start.
// - Reference codes 010,100,110,111 mean internal reference.
module acs_sequencer (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire acs_pkg::acs_ctl_wr_t ctl_wr,
    input wire logic done_flag_clr,
    input wire logic [1:0] conv_clock_select,
    input wire logic [2:0] reference_config,
    input wire logic [3:0] capture_compare_mode,
    input wire logic result_right_justify,
    input wire logic special_event,
    input wire logic rc_osc,
    input wire logic comparator_in,
    output logic converter_on_r,
    output logic conv_busy_r,
    output logic conversion_done_flag_r,
    output logic timer_clear_r,
    output logic settling_r,
    output logic [acs_pkg::ACS_RES_BITS-1:0] dac_trial_r,
    output acs_pkg::acs_result_t result_r
);
    import acs_pkg::*;

    logic rc_s1_r;
    logic rc_s2_r;
    logic rc_s3_r;
    logic cmp_s1_r;
    logic cmp_s2_r;
    logic cmp_s3_r;
    logic cmp_r;
    logic use_rc_r;
    logic [ACS_PERIOD_W-1:0] period_r;
    logic [3:0] tad_idx_r;
    logic [ACS_RES_BITS-1:0] mask_r;
    logic tick;
    logic tad_rise;
    logic tad_fall;
    logic sw_start;
    logic sw_abort;
    logic ev_start;
    logic start;
    logic finish;
    logic [ACS_RES_BITS-1:0] decided;

    // ==================================================================
    // Input synchronisers
    // ==================================================================
    // Three stages; a comparator change counts once the second and third agree, an RC edge while they differ.
    always_ff @(posedge sys_clk) begin
        rc_s1_r <= rc_osc;
        rc_s2_r <= rc_s1_r;
        rc_s3_r <= rc_s2_r;
    end

    always_ff @(posedge sys_clk) begin
        cmp_s1_r <= comparator_in;
        cmp_s2_r <= cmp_s1_r;
        cmp_s3_r <= cmp_s2_r;
        if (cmp_s2_r == cmp_s3_r) begin
            cmp_r <= cmp_s3_r;
        end
    end

    // Each RC edge is one tick; the RC period is thus two ticks.
    assign tick = use_rc_r ? (rc_s2_r != rc_s3_r) : 1'b1;

    // ==================================================================
    // Start and abort decode
    // ==================================================================
    // A write that switches the converter on cannot also start it.
    assign sw_start = ctl_wr.wr && ctl_wr.start && converter_on_r &&
                      ctl_wr.converter_on && !conv_busy_r;
    assign sw_abort = ctl_wr.wr && !ctl_wr.start && conv_busy_r;
    assign ev_start = special_event && converter_on_r &&
        (capture_compare_mode == ACS_MODE_SPECIAL_EVENT) &&
        !conv_busy_r;
    assign start = (sw_start || ev_start) && !sw_abort;
    assign finish = conv_busy_r && tad_rise && (tad_idx_r == ACS_TAD_LAST);

    // ==================================================================
    // Period selection
    // ==================================================================
    // The period is frozen at start so a mid-conversion change of the
    // select fields cannot produce a short period.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            period_r <= ACS_TICKS_OSC2;
            use_rc_r <= 1'b0;
        end else if (start) begin
            period_r <= tad_ticks(conv_clock_select,
                internal_ref_used(reference_config));
            use_rc_r <= (conv_clock_select == ACS_CLK_RC);
        end
    end

    acs_tad_divider #(
        .PERIOD_W(ACS_PERIOD_W)
    ) u_div (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .restart(start || !conv_busy_r),
        .tick(tick),
        .period(period_r),
        .tad_rise(tad_rise),
        .tad_fall(tad_fall)
    );

    // ==================================================================
    // Control bits
    // ==================================================================
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            converter_on_r <= 1'b0;
        end else if (ctl_wr.wr) begin
            converter_on_r <= ctl_wr.converter_on;
        end
    end

    // Busy stays up into the completion period and drops on its fall.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            conv_busy_r <= 1'b0;
        end else if (start) begin
            conv_busy_r <= 1'b1;
        end else if (sw_abort) begin
            conv_busy_r <= 1'b0;
        end else if (tad_fall && tad_idx_r > ACS_TAD_LAST) begin
            conv_busy_r <= 1'b0;
        end
    end

    // Completion wins over a clear in the same cycle.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            conversion_done_flag_r <= 1'b0;
        end else if (finish) begin
            conversion_done_flag_r <= 1'b1;
        end else if (done_flag_clr) begin
            conversion_done_flag_r <= 1'b0;
        end
    end

    // The timer is cleared by every trigger, whether or not on.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            timer_clear_r <= 1'b0;
        end else begin
            timer_clear_r <= special_event &&
                (capture_compare_mode == ACS_MODE_SPECIAL_EVENT);
        end
    end

    // ==================================================================
    // Period counter and approximation register
    // ==================================================================
    // Index 0 is the settling period; indices 1 to 12 resolve bits from
    // the top down; index 13 is the completion period.
    always_ff @(posedge sys_clk) begin
        if (sys_rst || start) begin
            tad_idx_r <= ACS_TAD_SETTLE;
            mask_r <= '0;
            dac_trial_r <= '0;
            settling_r <= start;
        end else if (conv_busy_r && tad_rise) begin
            tad_idx_r <= tad_idx_r + 4'h1;
            settling_r <= 1'b0;
            mask_r <= (tad_idx_r == ACS_TAD_SETTLE) ? ACS_MSB_MASK
                                                    : (mask_r >> 1);
            if (tad_idx_r == ACS_TAD_SETTLE) begin
                dac_trial_r <= ACS_MSB_MASK;
            end else if (tad_idx_r <= ACS_TAD_LAST) begin
                dac_trial_r <= (cmp_r ? dac_trial_r : (dac_trial_r & ~mask_r))
                               | (mask_r >> 1);
            end
        end else if (!conv_busy_r) begin
            settling_r <= 1'b0;
        end
    end

    // Bits still undecided read as zero in a partial result.
    assign decided = cmp_r ? dac_trial_r : (dac_trial_r & ~mask_r);

    // ==================================================================
    // Result bytes
    // ==================================================================
    // No reset here: the bytes keep their contents through a reset.
    always_ff @(posedge sys_clk) begin
        if (finish || sw_abort) begin
            if (result_right_justify) begin
                result_r <= {4'h0, (sw_abort ? (dac_trial_r & ~mask_r)
                                             : decided)};
            end else begin
                result_r <= {(sw_abort ? (dac_trial_r & ~mask_r)
                                       : decided), 4'h0};
            end
        end
    end

endmodule : acs_sequencer

/* logic/acs_tad_divider.sv */
// Conversion-period divider: turns ticks into rise and fall enables.
// Assumes tick and restart come from logic on sys_clk; period is at
// least two ticks and stays steady while a conversion runs.
module acs_tad_divider #(
    parameter int PERIOD_W = 9
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic restart,
    input wire logic tick,
    input wire logic [PERIOD_W-1:0] period,
    output logic tad_rise,
    output logic tad_fall
);
    import acs_pkg::*;

    logic [PERIOD_W-1:0] cnt_r;
    logic [PERIOD_W-1:0] cnt_nxt;
    logic [PERIOD_W-1:0] half;

    assign cnt_nxt = cnt_r + 1'b1;
    assign half = period >> 1;

    // ==================================================================
    // Tick counter
    // ==================================================================
    // A restart empties the count so the first period is a full one.
    always_ff @(posedge sys_clk) begin
        if (sys_rst || restart) begin
            cnt_r <= '0;
            tad_rise <= 1'b0;
            tad_fall <= 1'b0;
        end else begin
            tad_rise <= 1'b0;
            tad_fall <= 1'b0;
            if (tick) begin
                if (cnt_nxt == period) begin
                    cnt_r <= '0;
                    tad_rise <= 1'b1;
                end else begin
                    cnt_r <= cnt_nxt;
                    tad_fall <= (cnt_nxt == half);
                end
            end
        end
    end

endmodule : acs_tad_divider

/* testbench/acs_sequencer_asserts.sv */
// Checker for the conversion sequencer, bound to its top module.
// Assumes clock select and reference stay steady while a run is busy.
module acs_sequencer_asserts
    import acs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire acs_pkg::acs_ctl_wr_t ctl_wr,
    input wire logic [1:0] conv_clock_select,
    input wire logic [2:0] reference_config,
    input wire logic [3:0] capture_compare_mode,
    input wire logic special_event,
    input wire logic converter_on_r,
    input wire logic conv_busy_r,
    input wire logic conversion_done_flag_r,
    input wire logic timer_clear_r,
    input wire logic settling_r,
    input wire logic [ACS_RES_BITS-1:0] dac_trial_r
);
    // ====================
    // Busy counter and latched period
    // ====================
    logic [11:0] cnt_r;
    logic [11:0] per_r;
    logic [11:0] base;
    logic [11:0] per_nxt;
    logic rc_r;
    logic trig;
    logic go;
    assign trig = special_event &&
                  capture_compare_mode == ACS_MODE_SPECIAL_EVENT;
    assign go = ctl_wr.wr && ctl_wr.start && ctl_wr.converter_on;
    assign base = conv_clock_select == 2'h0 ? 12'h002 :
                  conv_clock_select == 2'h1 ? 12'h008 : 12'h020;
    assign per_nxt = reference_config inside {3'h2, 3'h4, 3'h6, 3'h7} ?
                     base << 3 : base;
    always_ff @(posedge sys_clk) begin
        cnt_r <= (sys_rst || !conv_busy_r) ? 12'h000 : cnt_r + 12'h001;
    end
    // RC periods are not a whole number of system cycles, so RC is exempt.
    always_ff @(posedge sys_clk) begin
        if (!conv_busy_r) begin
            per_r <= per_nxt;
            rc_r <= conv_clock_select == 2'h3;
        end
    end
    // ====================
    // Properties
    // ====================
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    wr_start_a: assert property (
        go && converter_on_r && !conv_busy_r |=> conv_busy_r && settling_r)
        else $error("write start missed");
    trig_start_a: assert property (
        trig && converter_on_r && !conv_busy_r |=> conv_busy_r)
        else $error("trigger start missed");
    timer_clr_a: assert property (
        trig |=> timer_clear_r)
        else $error("timer clear missed");
    on_start_a: assert property (
        go && !converter_on_r && !conv_busy_r |=> !conv_busy_r)
        else $error("start ran in turn-on write");
    abort_run_a: assert property (
        ctl_wr.wr && !ctl_wr.start && conv_busy_r |=> !conv_busy_r)
        else $error("abort ignored");
    done_time_a: assert property (
        $rose(conversion_done_flag_r) && !rc_r |-> cnt_r == 13 * per_r + 1)
        else $error("done flag at wrong time");
    busy_end_a: assert property (
        $fell(conv_busy_r) && !$past(sys_rst) && !rc_r &&
        $past(cnt_r) > 13 * per_r |-> $past(cnt_r) == 13 * per_r + per_r / 2)
        else $error("busy cleared at wrong time");
    // The settling period ends with the top bit as the first trial.
    trial_msb_a: assert property (
        $fell(settling_r) && conv_busy_r |-> dac_trial_r == ACS_MSB_MASK)
        else $error("first trial code wrong");
    rst_off_a: assert property (
        $fell(sys_rst) |-> !converter_on_r && !conv_busy_r &&
        !conversion_done_flag_r && !timer_clear_r && !settling_r)
        else $error("state not cleared by reset");
endmodule : acs_sequencer_asserts

bind acs_sequencer acs_sequencer_asserts u_asserts (.sys_clk, .sys_rst,
    .ctl_wr, .conv_clock_select, .reference_config, .capture_compare_mode,
    .special_event, .converter_on_r, .conv_busy_r, .conversion_done_flag_r,
    .timer_clear_r, .settling_r, .dac_trial_r);

/* testbench/acs_sequencer_tb_top.sv */
// Self-checking bench for the conversion sequencer.
// Assumes the checker is bound in; the comparator level is held steady
// through each run so that every decided bit is known.
module acs_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import acs_pkg::*;
    typedef struct packed {
        logic [1:0] sel;
        logic [2:0] vref;
        logic comp;
        logic rj;
        logic [8:0] per;
    } acs_tb_row_t;
    logic sys_clk, sys_rst, done_flag_clr, result_right_justify;
    logic special_event, comparator_in, converter_on_r, conv_busy_r;
    logic conversion_done_flag_r, timer_clear_r, settling_r;
    logic rc_osc = 1'b0;
    logic [1:0] conv_clock_select;
    logic [2:0] reference_config;
    logic [3:0] capture_compare_mode;
    acs_ctl_wr_t ctl_wr;
    acs_result_t result_r;
    int err_count = 0;
    int n_compared = 0;
    int rc_div = 0;
    acs_tb_row_t rows[10] = '{'{2'h0, 3'h0, 1'b1, 1'b0, 9'h002},
        '{2'h1, 3'h1, 1'b1, 1'b1, 9'h008}, '{2'h2, 3'h3, 1'b0, 1'b0, 9'h020},
        '{2'h0, 3'h2, 1'b1, 1'b1, 9'h010}, '{2'h0, 3'h4, 1'b0, 1'b1, 9'h010},
        '{2'h0, 3'h6, 1'b1, 1'b0, 9'h010}, '{2'h0, 3'h7, 1'b1, 1'b1, 9'h010},
        '{2'h1, 3'h5, 1'b0, 1'b0, 9'h008}, '{2'h1, 3'h2, 1'b1, 1'b0, 9'h040},
        '{2'h2, 3'h4, 1'b1, 1'b1, 9'h100}};
    acs_sequencer uut (.sys_clk, .sys_rst, .ctl_wr, .done_flag_clr,
        .conv_clock_select, .reference_config, .capture_compare_mode,
        .result_right_justify, .special_event, .rc_osc, .comparator_in,
        .converter_on_r, .conv_busy_r, .conversion_done_flag_r,
        .timer_clear_r, .settling_r, .dac_trial_r(), .result_r);
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // The RC source toggles every 15 cycles, unrelated to any start.
    always @(posedge sys_clk) begin
        rc_div <= (rc_div == 14) ? 0 : rc_div + 1;
        if (rc_div == 14) rc_osc <= ~rc_osc;
    end
    // ====================
    // Tasks
    // ====================
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    task automatic final_report();
        $display("compared %0d, mismatched %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report
    task automatic wr(input logic on, input logic go);
        @(posedge sys_clk);
        ctl_wr <= '{wr: 1'b1, converter_on: on, start: go};
        @(posedge sys_clk);
        ctl_wr <= '0;
    endtask : wr
    task automatic setup(input logic [1:0] sel, input logic [2:0] vref,
                         input logic comp, input logic rj);
        @(posedge sys_clk);
        conv_clock_select <= sel;
        reference_config <= vref;
        comparator_in <= comp;
        result_right_justify <= rj;
        // Gives the comparator synchroniser time to settle.
        repeat (6) @(posedge sys_clk);
    endtask : setup
    task automatic run(output int t_done, output int t_idle);
        int n = 0;
        t_done = 0;
        do begin
            @(negedge sys_clk);
            n++;
            if (t_done == 0 && conversion_done_flag_r === 1'b1) t_done = n;
        end while (conv_busy_r === 1'b1 && n < 4000);
        t_idle = n;
    endtask : run
    task automatic clr_flag();
        @(posedge sys_clk);
        done_flag_clr <= 1'b1;
        @(posedge sys_clk);
        done_flag_clr <= 1'b0;
        @(negedge sys_clk);
        check("flag clear", conversion_done_flag_r, 1'b0);
    endtask : clr_flag
    task automatic trig(input logic [3:0] mode, input logic clr_exp,
                        input logic busy_exp);
        @(posedge sys_clk);
        capture_compare_mode <= mode;
        special_event <= 1'b1;
        @(posedge sys_clk);
        special_event <= 1'b0;
        @(negedge sys_clk);
        check("timer clear", timer_clear_r, clr_exp);
        check("trigger busy", conv_busy_r, busy_exp);
    endtask : trig
    // ====================
    // Sequence
    // ====================
    initial begin
        int t_done;
        int t_idle;
        int p;
        sys_rst = 1'b1;
        ctl_wr = '0;
        done_flag_clr = 1'b0;
        special_event = 1'b0;
        capture_compare_mode = 4'h0;
        conv_clock_select = 2'h0;
        reference_config = 3'h0;
        comparator_in = 1'b1;
        result_right_justify = 1'b0;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(negedge sys_clk);
        check("reset start", {converter_on_r, conv_busy_r}, 2'b00);
        check("reset flag", conversion_done_flag_r, 1'b0);
        wr(1'b1, 1'b0);
        for (int i = 0; i < 10; i++) begin
            setup(rows[i].sel, rows[i].vref, rows[i].comp, rows[i].rj);
            wr(1'b1, 1'b1);
            run(t_done, t_idle);
            p = rows[i].per;
            // Counting starts at the edge that takes the write, and the
            // flag lands one cycle after the registered period edge.
            check("done time", t_done, 13 * p + 2);
            check("busy end", t_idle, 13 * p + 2 + p / 2);
            check("result", result_r, !rows[i].comp ? 16'h0000 :
                  rows[i].rj ? 16'h0fff : 16'hfff0);
            clr_flag();
            $display("row %0d finished", i);
        end
        setup(2'h0, 3'h0, 1'b1, 1'b0);
        trig(ACS_MODE_SPECIAL_EVENT, 1'b1, 1'b1);
        run(t_done, t_idle);
        check("trigger run", t_done, 16'h001b);
        clr_flag();
        wr(1'b0, 1'b0);
        trig(ACS_MODE_SPECIAL_EVENT, 1'b1, 1'b0);
        trig(4'ha, 1'b0, 1'b0);
        wr(1'b1, 1'b1);
        @(negedge sys_clk);
        check("turn-on start", {converter_on_r, conv_busy_r}, 2'b10);
        $display("trigger and turn-on tests finished");
        setup(2'h1, 3'h0, 1'b1, 1'b0);
        wr(1'b1, 1'b1);
        // Aborts midway between the third and fourth decided bits.
        repeat (36) @(negedge sys_clk);
        wr(1'b1, 1'b0);
        @(negedge sys_clk);
        check("abort busy", {conv_busy_r, conversion_done_flag_r}, 0);
        check("abort result", result_r, 16'he000);
        setup(2'h1, 3'h0, 1'b0, 1'b0);
        wr(1'b1, 1'b1);
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(negedge sys_clk);
        check("reset result", result_r, 16'he000);
        check("reset state", {converter_on_r, conv_busy_r}, 2'b00);
        $display("abort and reset tests finished");
        wr(1'b1, 1'b0);
        setup(2'h3, 3'h0, 1'b1, 1'b0);
        wr(1'b1, 1'b1);
        run(t_done, t_idle);
        check("rc window", t_done >= 370 && t_done <= 405, 1'b1);
        check("rc result", result_r, 16'hfff0);
        $display("rc test finished");
        final_report();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        $display("watchdog expired");
        final_report();
    end
endmodule : acs_sequencer_tb_top
